// File: include/rtchld_defs.svh
// Constants for the count-hold and half-minute adjust block.
// Assumes a 25 MHz system clock and APB register access.
`ifndef RTCHLD_DEFS_SVH
`define RTCHLD_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RTCHLD_OFF_CTRL 12'h000
`define RTCHLD_OFF_STAT 12'h004
`define RTCHLD_OFF_IRQ_STAT 12'h008
`define RTCHLD_OFF_IRQ_MASK 12'h00C
`define RTCHLD_OFF_TIME_LO 12'h010
`define RTCHLD_OFF_TIME_HI 12'h014
`define RTCHLD_OFF_CMD 12'h018
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTCHLD_CTRL_HALT 2
`define RTCHLD_CTRL_FREEZE 3
`define RTCHLD_CTRL_BUSY_OUT 4
`define RTCHLD_CMD_ROUND 0
`define RTCHLD_IRQ_SEC 0
`define RTCHLD_IRQ_ADJ_DONE 1
`define RTCHLD_IRQ_BITS 2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTCHLD_CLK_HZ 25000000
`define RTCHLD_TICK_HZ 1
`define RTCHLD_DIV_COUNT (`RTCHLD_CLK_HZ / `RTCHLD_TICK_HZ)
`define RTCHLD_HALF_MINUTE_S 30
`endif

// File: include/rtchld_pkg.sv
// Types for the count-hold and half-minute adjust block.
// Assumes rtchld_defs.svh is compiled alongside.
package rtchld_pkg;
	typedef struct packed {
		logic [3:0] yr10;
		logic [3:0] yr1;
		logic [3:0] mon10;
		logic [3:0] mon1;
		logic [3:0] day10;
		logic [3:0] day1;
		logic [3:0] hr10;
		logic [3:0] hr1;
		logic [3:0] min10;
		logic [3:0] min1;
		logic [3:0] sec10;
		logic [3:0] sec1;
	} rtchld_time_t;
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} rtchld_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rtchld_apb_rsp_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CARRY = 3'b010,
		ST_DONE = 3'b100
	} rtchld_adj_state_t;
endpackage : rtchld_pkg

// File: verif/rtchld_host.sv
// Host model: an APB master driven by the bench through xfer.
// Assumes the bench top is rtchld_top_tb with give_verdict.
`timescale 1ns/100ps
module rtchld_host (
	input wire logic clk, // Clock.
	input wire rtchld_pkg::rtchld_apb_rsp_t apb_rsp, // Answer.
	output rtchld_pkg::rtchld_apb_req_t apb_req // Request.
);
	import rtchld_pkg::*;
	initial apb_req = '0;
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		apb_req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		if (apb_rsp.pready !== 1'b1) begin
			rtchld_top_tb.miscompares++;
			rtchld_top_tb.give_verdict();
		end
		r = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge clk);
	endtask : xfer
endmodule : rtchld_host

// File: verif/rtchld_props.sv
// Concurrent checks on the top ports of the count-hold block.
// Assumes aligned APB addresses; CTRL is mirrored from bus writes.
`timescale 1ns/100ps
`include "rtchld_defs.svh"
module rtchld_props (
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire rtchld_pkg::rtchld_apb_req_t apb_req, // Request.
	input wire rtchld_pkg::rtchld_apb_rsp_t apb_rsp, // Answer.
	input wire logic alarm_src, // Pin one source.
	input wire logic interval_src, // Pin two source.
	input wire logic alarm_pulse_pin, // Pin one.
	input wire logic interval_pulse_pin, // Pin two.
	input wire logic busy, // Busy.
	input wire logic irq // Interrupt.
);
	import rtchld_pkg::*;
	logic acc, umap, wr_ctrl, wr_rnd, sel_reg, hold_reg;
	assign acc = apb_req.psel && apb_req.penable;
	assign umap = apb_req.paddr > `RTCHLD_OFF_CMD;
	assign wr_ctrl = acc && apb_req.pwrite && apb_req.paddr == `RTCHLD_OFF_CTRL;
	assign wr_rnd = acc && apb_req.pwrite && apb_req.paddr == `RTCHLD_OFF_CMD && apb_req.pwdata[0];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else if (wr_ctrl) begin
			sel_reg <= apb_req.pwdata[`RTCHLD_CTRL_BUSY_OUT];
			hold_reg <= apb_req.pwdata[`RTCHLD_CTRL_HALT] | apb_req.pwdata[`RTCHLD_CTRL_FREEZE];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	zero_wait_a: assert property (acc |-> apb_rsp.pready) else $error("pready low in access");
	bad_addr_a: assert property (acc |-> apb_rsp.pslverr == umap) else $error("pslverr wrong");
	bad_read_a: assert property (acc && !apb_req.pwrite && umap |-> apb_rsp.prdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!(apb_req.psel && !apb_req.penable && !apb_req.pwrite) |=>
		$stable(apb_rsp.prdata)) else $error("read data moved");
	round_busy_a: assert property (wr_rnd |=> busy [*2]) else $error("busy short in rounding");
	hold_quiet_a: assert property (hold_reg && !busy && !wr_rnd ##1 hold_reg |-> !busy)
		else $error("time advanced while held");
	pin_busy_a: assert property ($past(rst_n) && $past(sel_reg) |->
		alarm_pulse_pin == $past(busy) && interval_pulse_pin == $past(busy)) else $error("pins not busy");
	pin_src_a: assert property ($past(rst_n) && !$past(sel_reg) |->
		alarm_pulse_pin == $past(alarm_src) && interval_pulse_pin == $past(interval_src))
		else $error("pins not sources");
	cover property (wr_rnd);
	cover property (wr_ctrl && hold_reg);
	cover property (acc && umap);
endmodule : rtchld_props

// File: verif/rtchld_top_tb.sv
// Self-checking bench for the count-hold and rounding block.
// Assumes the one-second tick never falls within the run.
`timescale 1ns/100ps
`include "rtchld_defs.svh"
module rtchld_top_tb;
	import rtchld_pkg::*;
	logic clk, rst_n, alarm_src, interval_src, alarm_pulse_pin, interval_pulse_pin, busy, irq, er;
	rtchld_apb_req_t apb_req;
	rtchld_apb_rsp_t apb_rsp;
	logic [31:0] rd;
	int miscompares = 0, n_compared = 0, bcnt = 0, pcnt = 0;
	rtchld_top i_dut (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .alarm_src(alarm_src),
		.interval_src(interval_src), .alarm_pulse_pin(alarm_pulse_pin),
		.interval_pulse_pin(interval_pulse_pin), .busy(busy), .irq(irq));
	rtchld_host i_host (.clk(clk), .apb_rsp(apb_rsp), .apb_req(apb_req));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		bcnt <= bcnt + int'(busy);
		pcnt <= pcnt + int'(alarm_pulse_pin & interval_pulse_pin);
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rd, er);
	endtask : wr
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		i_host.xfer(1'b0, a, 32'h0, rd, er);
		chk(nm, exp, rd);
	endtask : rdc
	task automatic t_reset();
		for (int i = 0; i < 6; i++) rdc("reset value", 12'(i * 4), 32'h0);
		chk("pins", 32'h0, 32'({alarm_pulse_pin, interval_pulse_pin}));
	endtask : t_reset
	task automatic t_hold();
		wr(`RTCHLD_OFF_CTRL, 32'h8);
		rdc("freeze bit", `RTCHLD_OFF_CTRL, 32'h8);
		rdc("hold flag", `RTCHLD_OFF_STAT, 32'h2);
		wr(`RTCHLD_OFF_TIME_LO, 32'h1);
		rdc("frozen time", `RTCHLD_OFF_TIME_LO, 32'h0);
		wr(`RTCHLD_OFF_CTRL, 32'h0);
		rdc("released", `RTCHLD_OFF_STAT, 32'h0);
		i_host.xfer(1'b0, 12'h01C, 32'h0, rd, er);
		chk("unmapped error", 32'h1, 32'(er));
		chk("unmapped data", 32'h0, rd);
	endtask : t_hold
	task automatic t_round(input logic [31:0] lo, hi, elo, ehi, mask);
		int b0, p0;
		wr(`RTCHLD_OFF_CTRL, 32'h4);
		wr(`RTCHLD_OFF_TIME_LO, lo);
		wr(`RTCHLD_OFF_TIME_HI, hi);
		rdc("set time", `RTCHLD_OFF_TIME_LO, lo);
		wr(`RTCHLD_OFF_CTRL, 32'h10);
		wr(`RTCHLD_OFF_IRQ_MASK, mask);
		alarm_src <= 1'b1;
		interval_src <= 1'b1;
		b0 = bcnt;
		p0 = pcnt;
		wr(`RTCHLD_OFF_CMD, 32'h1);
		repeat (6) @(posedge clk);
		chk("busy cycles", 32'd2, 32'(bcnt - b0));
		chk("pin busy cycles", 32'd2, 32'(pcnt - p0));
		chk("irq", 32'(mask[1]), 32'(irq));
		rdc("rounded low", `RTCHLD_OFF_TIME_LO, elo);
		rdc("rounded high", `RTCHLD_OFF_TIME_HI, ehi);
		rdc("adjust done", `RTCHLD_OFF_IRQ_STAT, 32'h2);
		wr(`RTCHLD_OFF_IRQ_STAT, 32'h2);
		rdc("flag cleared", `RTCHLD_OFF_IRQ_STAT, 32'h0);
		chk("irq cleared", 32'h0, 32'(irq));
		wr(`RTCHLD_OFF_CTRL, 32'h0);
		alarm_src <= 1'b0;
		repeat (2) @(posedge clk);
		chk("pins follow", 32'h1, 32'({alarm_pulse_pin, interval_pulse_pin}));
	endtask : t_round
	task automatic give_verdict();
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		rst_n = 1'b0;
		alarm_src = 1'b0;
		interval_src = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_hold();
		t_round(32'h3123_5945, 32'h0000_9912, 32'h0100_0000, 32'h0000_0001, 32'h2);
		t_round(32'h1512_3429, 32'h0000_4206, 32'h1512_3400, 32'h0000_4206, 32'h0);
		give_verdict();
	end
endmodule : rtchld_top_tb
bind rtchld_top rtchld_props i_props (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.alarm_src(alarm_src), .interval_src(interval_src), .alarm_pulse_pin(alarm_pulse_pin),
	.interval_pulse_pin(interval_pulse_pin), .busy(busy), .irq(irq));

// File: verilog/rtchld_digit.sv
// One BCD time digit with increment, carry out and load.
// Assumes the caller supplies the wrap limit for this digit.
`timescale 1ns/100ps
`include "rtchld_defs.svh"
module rtchld_digit (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic inc, // Increment this digit.
	input wire logic clr, // Force digit to its floor value.
	input wire logic load, // Load new value.
	input wire logic [3:0] load_val, // Value to load.
	input wire logic [3:0] limit, // Last value before wrap.
	input wire logic [3:0] floor_val, // Value after wrap.
	output logic [3:0] value, // Current digit.
	output logic carry // Increment would wrap.
);
	logic [3:0] value_reg;
	assign value = value_reg;
	assign carry = inc && (value_reg >= limit);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			value_reg <= 4'h0;
		end else if (load) begin
			value_reg <= load_val;
		end else if (clr) begin
			value_reg <= floor_val;
		end else if (inc) begin
			value_reg <= (value_reg >= limit) ? floor_val : value_reg + 4'h1;
		end
	end
endmodule : rtchld_digit

// File: verilog/rtchld_top.sv
// Count-hold, half-minute rounding and busy logic of a calendar clock, with APB registers.
// Assumes a 25 MHz clock, a synchronous active-low reset and a well-behaved APB master.
//
// Function
// R1 - Rounding adjust carries through every digit
// R2 - Busy stays high until carry finishes
// R3 - Control bit three freezes counting for reads
// R4 - Freeze or halt blocks tick to counters
// R5 - Host halts counting while setting time
// R6 - Host freezes, checks busy, or reads twice
// R7 - Quick release loses no pending tick
// R8 - Divider runs on; held tick applied later
// R9 - Busy select drives both pulse pins only
`timescale 1ns/100ps
`include "rtchld_defs.svh"
module rtchld_top (
	input wire logic clk, // System clock, 25 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire rtchld_pkg::rtchld_apb_req_t apb_req, // APB request.
	output rtchld_pkg::rtchld_apb_rsp_t apb_rsp, // APB answer.
	input wire logic alarm_src, // Alarm waveform from the alarm logic.
	input wire logic interval_src, // Interval waveform from the timer logic.
	output logic alarm_pulse_pin, // Timing pulse pin one.
	output logic interval_pulse_pin, // Timing pulse pin two.
	output logic busy, // Counting or carry in progress.
	output logic irq // Level interrupt.
);
	import rtchld_pkg::*;

	// ----------------------------------------------------------------
	// Registers and bus decode
	// ----------------------------------------------------------------
	localparam int NDIG = 12;
	logic [7:0] ctrl_reg;
	logic [`RTCHLD_IRQ_BITS-1:0] irq_stat_reg;
	logic [`RTCHLD_IRQ_BITS-1:0] irq_mask_reg;
	logic [31:0] prdata_reg;
	logic wr_acc;
	logic rd_acc;
	logic freeze;
	logic halt;
	logic hold;
	assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	assign freeze = ctrl_reg[`RTCHLD_CTRL_FREEZE]; // R3
	assign halt = ctrl_reg[`RTCHLD_CTRL_HALT];
	assign hold = freeze || halt;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a == off);
	endfunction : addr_is

	function automatic logic mapped(input logic [11:0] a);
		mapped = addr_is(a, `RTCHLD_OFF_CTRL) || addr_is(a, `RTCHLD_OFF_STAT) ||
			addr_is(a, `RTCHLD_OFF_IRQ_STAT) || addr_is(a, `RTCHLD_OFF_IRQ_MASK) ||
			addr_is(a, `RTCHLD_OFF_TIME_LO) || addr_is(a, `RTCHLD_OFF_TIME_HI) ||
			addr_is(a, `RTCHLD_OFF_CMD);
	endfunction : mapped

	// ----------------------------------------------------------------
	// Divider and held tick
	// ----------------------------------------------------------------
	logic [24:0] div_reg;
	logic sec_tick;
	logic tick_pending_reg;
	logic apply_tick;
	assign sec_tick = (div_reg == 25'(`RTCHLD_DIV_COUNT - 1));

	// The divider never stops, so a released hold keeps the second phase.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_reg <= 25'h0000000;
		end else if (sec_tick) begin // R8
			div_reg <= 25'h0000000;
		end else begin
			div_reg <= div_reg + 25'h0000001;
		end
	end

	// A tick during a hold is kept and counted once the hold ends.
	// Setting the time leaves it pending, since neither the divider nor the held tick is reset by it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_pending_reg <= 1'b0;
		end else if (hold && sec_tick) begin // R7
			tick_pending_reg <= 1'b1;
		end else if (apply_tick) begin // R8
			tick_pending_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Half-minute rounding state machine
	// ----------------------------------------------------------------
	rtchld_adj_state_t adj_state_reg;
	logic round_cmd;
	logic round_up;
	logic round_clr;
	logic adj_done;
	logic [3:0] sec10_v;
	assign round_cmd = wr_acc && addr_is(apb_req.paddr, `RTCHLD_OFF_CMD) && apb_req.pwdata[`RTCHLD_CMD_ROUND];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			adj_state_reg <= ST_IDLE;
		end else begin
			unique case (adj_state_reg)
				ST_IDLE: begin
					if (round_cmd) begin
						adj_state_reg <= ST_CARRY;
					end
				end
				ST_CARRY: begin
					adj_state_reg <= ST_DONE; // R2
				end
				ST_DONE: begin
					adj_state_reg <= ST_IDLE;
				end
				default: begin
					adj_state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Seconds at or above thirty round up to the next minute, which carries through all digits.
	assign round_clr = (adj_state_reg == ST_CARRY);
	assign round_up = round_clr && (sec10_v >= 4'h3); // R1
	assign adj_done = (adj_state_reg == ST_DONE);
	assign apply_tick = !hold && !round_clr && (sec_tick || tick_pending_reg); // R4

	// ----------------------------------------------------------------
	// Time digits
	// ----------------------------------------------------------------
	logic [NDIG-1:0] dig_inc;
	logic [NDIG-1:0] dig_carry;
	logic [NDIG-1:0] dig_load;
	logic [NDIG-1:0] dig_clr;
	logic [3:0] dig_val [NDIG];
	logic [3:0] dig_lim [NDIG];
	logic [3:0] dig_floor [NDIG];
	rtchld_time_t now;
	logic time_wr;
	assign time_wr = wr_acc && halt; // R5
	assign sec10_v = dig_val[1];

	// Digit limits: sec1, sec10, min1, min10, hr1, hr10, day1, day10, mon1, mon10, yr1, yr10.
	always_comb begin
		for (int i = 0; i < NDIG; i++) begin
			dig_lim[i] = 4'h9;
			dig_floor[i] = 4'h0;
		end
		dig_lim[1] = 4'h5;
		dig_lim[3] = 4'h5;
		dig_lim[4] = (dig_val[5] == 4'h2) ? 4'h3 : 4'h9;
		dig_lim[5] = 4'h2;
		dig_lim[6] = (dig_val[7] == 4'h3) ? 4'h1 : 4'h9;
		dig_lim[7] = 4'h3;
		// A day-tens digit that wraps in this same step ends at zero, so day one must follow.
		dig_floor[6] = (dig_val[7] == 4'h0 || dig_carry[7]) ? 4'h1 : 4'h0;
		dig_lim[8] = (dig_val[9] == 4'h1) ? 4'h2 : 4'h9;
		dig_lim[9] = 4'h1;
		dig_floor[8] = (dig_val[9] == 4'h0 || dig_carry[9]) ? 4'h1 : 4'h0;
	end

	assign dig_inc[0] = apply_tick;
	assign dig_inc[2] = dig_carry[1] || round_up; // R1
	assign dig_clr[0] = round_clr;
	assign dig_clr[1] = round_clr;

	genvar g;
	generate
		for (g = 0; g < NDIG; g++) begin : g_dig
			if (g != 0 && g != 2) begin : g_chain
				assign dig_inc[g] = dig_carry[g-1]; // R1
			end
			if (g > 1) begin : g_noclr
				assign dig_clr[g] = 1'b0;
			end
			assign dig_load[g] = time_wr &&
				addr_is(apb_req.paddr, (g < 8) ? `RTCHLD_OFF_TIME_LO : `RTCHLD_OFF_TIME_HI);
			rtchld_digit u_digit (
				.clk(clk),
				.rst_n(rst_n),
				.inc(dig_inc[g]),
				.clr(dig_clr[g]),
				.load(dig_load[g]),
				.load_val(apb_req.pwdata[(g % 8) * 4 +: 4]),
				.limit(dig_lim[g]),
				.floor_val(dig_floor[g]),
				.value(dig_val[g]),
				.carry(dig_carry[g])
			);
		end
	endgenerate

	always_comb begin
		now = {dig_val[11], dig_val[10], dig_val[9], dig_val[8], dig_val[7], dig_val[6],
			dig_val[5], dig_val[4], dig_val[3], dig_val[2], dig_val[1], dig_val[0]};
	end

	// Busy covers a counting step and the whole rounding ripple.
	assign busy = apply_tick || (adj_state_reg != ST_IDLE); // R2

	// ----------------------------------------------------------------
	// Control, interrupt and read registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= 8'h00;
		end else if (wr_acc && addr_is(apb_req.paddr, `RTCHLD_OFF_CTRL)) begin
			ctrl_reg <= apb_req.pwdata[7:0]; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_mask_reg <= 2'h0;
		end else if (wr_acc && addr_is(apb_req.paddr, `RTCHLD_OFF_IRQ_MASK)) begin
			irq_mask_reg <= apb_req.pwdata[`RTCHLD_IRQ_BITS-1:0];
		end
	end

	// Setting an event wins over a write-one clear in the same cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_reg <= 2'h0;
		end else begin
			for (int i = 0; i < `RTCHLD_IRQ_BITS; i++) begin
				if ((i == `RTCHLD_IRQ_SEC && apply_tick) || (i == `RTCHLD_IRQ_ADJ_DONE && adj_done)) begin
					irq_stat_reg[i] <= 1'b1;
				end else if (wr_acc && addr_is(apb_req.paddr, `RTCHLD_OFF_IRQ_STAT) && apb_req.pwdata[i]) begin
					irq_stat_reg[i] <= 1'b0;
				end
			end
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_reg <= 32'h00000000;
		end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			unique case (1'b1)
				addr_is(apb_req.paddr, `RTCHLD_OFF_CTRL): prdata_reg <= {24'h000000, ctrl_reg};
				addr_is(apb_req.paddr, `RTCHLD_OFF_STAT): prdata_reg <= {29'h0000000, tick_pending_reg, hold, busy};
				addr_is(apb_req.paddr, `RTCHLD_OFF_IRQ_STAT): prdata_reg <= {30'h0000000, irq_stat_reg};
				addr_is(apb_req.paddr, `RTCHLD_OFF_IRQ_MASK): prdata_reg <= {30'h0000000, irq_mask_reg};
				addr_is(apb_req.paddr, `RTCHLD_OFF_TIME_LO): prdata_reg <= now[31:0];
				addr_is(apb_req.paddr, `RTCHLD_OFF_TIME_HI): prdata_reg <= {16'h0000, now[47:32]};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign apb_rsp.prdata = prdata_reg;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped(apb_req.paddr);

	// ----------------------------------------------------------------
	// Timing pulse pins
	// ----------------------------------------------------------------
	// Busy select overrides both pins and leaves the interval setting untouched.
	logic alarm_pin_reg;
	logic interval_pin_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alarm_pin_reg <= 1'b1;
			interval_pin_reg <= 1'b1;
		end else if (ctrl_reg[`RTCHLD_CTRL_BUSY_OUT]) begin
			alarm_pin_reg <= busy; // R9
			interval_pin_reg <= busy; // R9
		end else begin
			alarm_pin_reg <= alarm_src;
			interval_pin_reg <= interval_src;
		end
	end
	assign alarm_pulse_pin = alarm_pin_reg;
	assign interval_pulse_pin = interval_pin_reg;
endmodule : rtchld_top
